// ### common/pmsf_pkg.sv
package pmsf_pkg;

  // Register addresses on the processor's special function bus
  localparam logic [7:0] PM_IRQ_ENABLE_ADDR = 8'hEC;
  localparam logic [7:0] SUPPLY_SWITCH_CFG_ADDR = 8'hF5;
  localparam logic [7:0] PM_IRQ_FLAGS_ADDR = 8'hF8;
  localparam logic [7:0] EXT_INT_WAKE_CFG_ADDR = 8'hFF;

  // Flag register bit positions
  localparam int FLAG_RESTORED = 7;
  localparam int FLAG_SUMMARY = 6;
  localparam int FLAG_SAG = 5;
  localparam int FLAG_RESERVED = 4;
  localparam int FLAG_SWITCHED = 3;
  localparam int FLAG_BATTERY = 2;
  localparam int FLAG_TO_BATTERY = 1;
  localparam int FLAG_DC_LOW = 0;

  // Enable register bit positions
  localparam int EN_RESTORED = 7;
  localparam int EN_READ_CLEAR = 6;
  localparam int EN_SAG = 5;
  localparam int EN_SWITCHED = 3;
  localparam int EN_BATTERY = 2;
  localparam int EN_TO_BATTERY = 1;
  localparam int EN_DC_INPUT = 0;

  // Enable bits that gate new flag events onto the summary flag
  localparam logic [7:0] EN_SUMMARY_MASK = 8'hAF;
  // Writable bits of each register; the rest read as zero
  localparam logic [7:0] EN_WRITE_MASK = 8'hEF;
  localparam logic [7:0] FLAG_WRITE_MASK = 8'hEF;

  // Pin configuration register fields
  localparam int PIN_CAL_EN = 7;
  localparam int PIN1_FN_LSB = 1;
  localparam int PIN1_FN_MSB = 3;
  localparam int PIN0_EN = 0;

  // Switchover policy field
  localparam int POLICY_LSB = 0;
  localparam int POLICY_MSB = 1;

  // Reset values
  localparam logic [7:0] PM_IRQ_ENABLE_RST = 8'h00;
  localparam logic [1:0] POLICY_RST = 2'h0;
  localparam logic [7:0] PM_IRQ_FLAGS_RST = 8'h00;
  localparam logic [2:0] PIN1_FN_RST = 3'h0;
  localparam logic PIN_BIT_RST = 1'b0;

  typedef enum logic [1:0] {
    POL_LOW_VDD,
    POL_LOW_VDD_AND_DC,
    POL_OFF_A,
    POL_OFF_B
  } pmsf_policy_e;

endpackage

// ### common/pmsf_sw_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pmsf_sw_if;
  import pmsf_pkg::*;
  logic main_low;
  logic dc_low;
  logic [1:0] policy;
  logic on_battery;
  logic to_battery;
  logic restored;

  modport ctrl (output main_low, output dc_low, output policy,
                input on_battery, input to_battery, input restored);
  modport sw (input main_low, input dc_low, input policy,
              output on_battery, output to_battery, output restored);
endinterface
`default_nettype wire

// ### core/pmsf_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pmsf_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pmsf_sync_s;

  pmsf_sync_s st_q;
  pmsf_sync_s st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d.meta = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;
endmodule
`default_nettype wire

// ### core/pmsf_switch.sv
`timescale 1ns/10ps
`default_nettype none
module pmsf_switch
  import pmsf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  pmsf_sw_if.sw sw
);
  typedef struct packed {
    logic on_battery;
    logic to_battery;
    logic restored;
  } pmsf_switch_s;

  pmsf_switch_s st_q;
  pmsf_switch_s st_d;
  logic allow;

  always_comb begin
    case (pmsf_policy_e'(sw.policy))
      POL_LOW_VDD: allow = sw.main_low;
      POL_LOW_VDD_AND_DC: allow = sw.main_low & sw.dc_low;
      default: allow = 1'b0;
    endcase
    st_d = st_q;
    st_d.to_battery = 1'b0;
    st_d.restored = 1'b0;
    if (!st_q.on_battery && allow) begin
      st_d.on_battery = 1'b1;
      st_d.to_battery = 1'b1;
    end else if (st_q.on_battery && !sw.main_low) begin
      // Return only once main supply is good, whatever the policy now says
      st_d.on_battery = 1'b0;
      st_d.restored = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sw.on_battery = st_q.on_battery;
  assign sw.to_battery = st_q.to_battery;
  assign sw.restored = st_q.restored;
endmodule
`default_nettype wire

// ### core/pmsf_top.sv
`timescale 1ns/10ps
`default_nettype none
module pmsf_top
  import pmsf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic main_supply_low,
  input wire logic dc_input_sense,
  input wire logic switched_supply_delta,
  input wire logic switched_supply_ready,
  input wire logic battery_threshold,
  input wire logic battery_ready,
  input wire logic line_sag,
  input wire logic rtc_1hz,
  input wire logic gpio_pin1_out,
  output logic calib_freq_out_a,
  output logic battery_control_out,
  output logic irq_pin1_o,
  output logic irq_pin1_oe,
  output logic irq_pin1_in_en,
  output logic irq_pin0_enable,
  output logic switched_supply,
  output logic meter_status_read_clear,
  output logic power_irq_summary_flag
);
  localparam int NSYNC = 9;

  typedef struct packed {
    logic [7:0] en;
    logic [1:0] policy;
    logic cal_en;
    logic [2:0] pin1_fn;
    logic pin0_en;
    logic [7:0] flags;
    logic [5:0] prev;
    logic [7:0] rdata;
    logic cal_out;
    logic batt_ctl;
    logic pin1_o;
    logic pin1_oe;
    logic pin1_in_en;
    logic pin0_out;
    logic on_batt;
    logic rd_clear;
  } pmsf_top_s;

  pmsf_top_s st_q;
  pmsf_top_s st_d;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  logic main_low_s;
  logic dc_low_s;
  logic delta_s;
  logic ready_s;
  logic bat_low_s;
  logic bat_ready_s;
  logic sag_s;
  logic tick_s;
  logic gpio_s;
  logic [5:0] levels;
  logic [5:0] rises;
  logic [7:0] set_ev;
  logic hit_en;
  logic hit_cfg;
  logic hit_flags;
  logic hit_pin;
  logic [7:0] read_mux;

  pmsf_sw_if swi ();

  // Analog monitor levels and the RTC tick come from other domains
  assign raw_in = {gpio_pin1_out, rtc_1hz, line_sag, battery_ready, battery_threshold,
                   switched_supply_ready, switched_supply_delta, dc_input_sense,
                   main_supply_low};

  pmsf_sync #(
    .W(NSYNC)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(raw_in),
    .sync_out(syn)
  );

  assign main_low_s = syn[0];
  assign dc_low_s = syn[1];
  assign delta_s = syn[2];
  assign ready_s = syn[3];
  assign bat_low_s = syn[4];
  assign bat_ready_s = syn[5];
  assign sag_s = syn[6];
  assign tick_s = syn[7];
  assign gpio_s = syn[8];

  assign swi.main_low = main_low_s;
  assign swi.dc_low = dc_low_s;
  assign swi.policy = st_q.policy;

  pmsf_switch u_switch (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sw(swi.sw)
  );

  // Monitor inputs are levels; only their rising edges count as events
  assign levels = {sag_s, bat_ready_s, bat_low_s, ready_s, delta_s, dc_low_s};
  assign rises = levels & ~st_q.prev;

  always_comb begin
    set_ev = 8'h00;
    set_ev[FLAG_RESTORED] = swi.restored;
    set_ev[FLAG_SAG] = rises[5];
    set_ev[FLAG_SWITCHED] = rises[1] | rises[2];
    set_ev[FLAG_BATTERY] = rises[3] | rises[4];
    set_ev[FLAG_TO_BATTERY] = swi.to_battery;
    set_ev[FLAG_DC_LOW] = rises[0];
    // Summary follows the enabled events themselves, not stale flags
    set_ev[FLAG_SUMMARY] = |(set_ev & st_q.en & EN_SUMMARY_MASK);
  end

  // Address decode
  assign hit_en = (sfr_addr == PM_IRQ_ENABLE_ADDR);
  assign hit_cfg = (sfr_addr == SUPPLY_SWITCH_CFG_ADDR);
  assign hit_flags = (sfr_addr == PM_IRQ_FLAGS_ADDR);
  assign hit_pin = (sfr_addr == EXT_INT_WAKE_CFG_ADDR);

  always_comb begin
    read_mux = 8'h00;
    if (hit_en) begin
      read_mux = st_q.en;
    end else if (hit_cfg) begin
      read_mux = {6'h00, st_q.policy};
    end else if (hit_flags) begin
      read_mux = st_q.flags;
    end else if (hit_pin) begin
      read_mux = {st_q.cal_en, 3'h0, st_q.pin1_fn, st_q.pin0_en};
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.prev = levels;
    st_d.on_batt = swi.on_battery;

    // Register writes
    if (sfr_wr && hit_en) begin
      st_d.en = sfr_wdata & EN_WRITE_MASK;
    end
    if (sfr_wr && hit_cfg) begin
      // Upper bits are held at zero by software; they are not stored
      st_d.policy = sfr_wdata[POLICY_MSB:POLICY_LSB];
    end
    if (sfr_wr && hit_pin) begin
      st_d.cal_en = sfr_wdata[PIN_CAL_EN];
      st_d.pin1_fn = sfr_wdata[PIN1_FN_MSB:PIN1_FN_LSB];
      st_d.pin0_en = sfr_wdata[PIN0_EN];
    end

    // Writing zero clears a flag, writing one leaves it; a new event wins
    if (sfr_wr && hit_flags) begin
      st_d.flags = st_q.flags & sfr_wdata;
    end
    st_d.flags = (st_d.flags | set_ev) & FLAG_WRITE_MASK;

    // Registered read data; unmapped addresses answer zero
    if (sfr_rd) begin
      st_d.rdata = read_mux;
    end

    // Calibration output follows the synchronised tick while enabled
    st_d.cal_out = st_q.cal_en & tick_s;

    // First interrupt pin function
    st_d.pin1_o = 1'b0;
    st_d.pin1_oe = 1'b0;
    st_d.pin1_in_en = 1'b0;
    st_d.batt_ctl = 1'b0;
    case (st_q.pin1_fn[1:0])
      2'b00: begin
        st_d.pin1_o = gpio_s;
        st_d.pin1_oe = 1'b1;
      end
      2'b01: begin
        st_d.batt_ctl = swi.on_battery;
        st_d.pin1_o = swi.on_battery;
        st_d.pin1_oe = 1'b1;
      end
      default: begin
        st_d.pin1_in_en = st_q.pin1_fn[2];
      end
    endcase
    st_d.pin0_out = st_q.pin0_en;

    st_d.rd_clear = st_q.en[EN_READ_CLEAR];
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.en <= PM_IRQ_ENABLE_RST;
      st_q.policy <= POLICY_RST;
      st_q.flags <= PM_IRQ_FLAGS_RST;
      st_q.pin1_fn <= PIN1_FN_RST;
      st_q.cal_en <= PIN_BIT_RST;
      st_q.pin0_en <= PIN_BIT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata = st_q.rdata;
  assign calib_freq_out_a = st_q.cal_out;
  assign battery_control_out = st_q.batt_ctl;
  assign irq_pin1_o = st_q.pin1_o;
  assign irq_pin1_oe = st_q.pin1_oe;
  assign irq_pin1_in_en = st_q.pin1_in_en;
  assign irq_pin0_enable = st_q.pin0_out;
  assign switched_supply = st_q.on_batt;
  assign meter_status_read_clear = st_q.rd_clear;
  assign power_irq_summary_flag = st_q.flags[FLAG_SUMMARY];
endmodule
`default_nettype wire

// ### verification/pmsf_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pmsf_monitor (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic main_supply_low,
  input wire logic calib_freq_out_a,
  input wire logic battery_control_out,
  input wire logic irq_pin1_oe,
  input wire logic irq_pin1_in_en,
  input wire logic irq_pin0_enable,
  input wire logic switched_supply,
  input wire logic meter_status_read_clear,
  input wire logic power_irq_summary_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic hit;
  logic pin_wr;
  assign hit = sfr_addr inside {8'hEC, 8'hF5, 8'hF8, 8'hFF};
  assign pin_wr = sfr_wr && sfr_addr == 8'hFF;
  a_unmapped_read_zero: assert property (
    sfr_rd && !hit |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (
    !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
  a_cal_off: assert property (
    pin_wr && !sfr_wdata[7] ##1 !pin_wr [*2] |=> !calib_freq_out_a)
    else $error("cal output while disabled");
  a_pin0_copy: assert property (
    pin_wr |-> ##2 irq_pin0_enable == $past(sfr_wdata[0], 2)) else $error("pin0 enable");
  a_pin1_in_decode: assert property (
    pin_wr |-> ##2 irq_pin1_in_en == ($past(sfr_wdata[3:2], 2) == 2'h3))
    else $error("pin1 input enable");
  a_read_clear_copy: assert property (
    sfr_wr && sfr_addr == 8'hEC |-> ##2 meter_status_read_clear == $past(sfr_wdata[6], 2))
    else $error("read clear bit");
  a_switch_needs_low: assert property (
    $rose(switched_supply) |-> $past(main_supply_low, 3)) else $error("switch without low");
  a_batt_ctl_follows: assert property (
    battery_control_out |-> switched_supply || $past(switched_supply))
    else $error("battery control off battery");
  a_input_no_drive: assert property (
    irq_pin1_in_en |-> !irq_pin1_oe) else $error("pin1 driven as input");
  a_summary_sticky: assert property (
    power_irq_summary_flag && !(sfr_wr && sfr_addr == 8'hF8) |=> power_irq_summary_flag)
    else $error("summary flag dropped");
endmodule
`default_nettype wire

// ### verification/tb_pmsf_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_pmsf_top;
  logic sys_clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, msl = 0, dcs = 0, rtc = 0, gpo = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, en, d;
  logic [4:0] ev = 0;
  logic calib, bctl, p1o, p1oe, p1ie, p0e, sws, rclr, sum;
  logic [31:0] seed = 32'h000165B9;
  int fails = 0, tests_run = 0;
  logic [7:0] adr [4] = '{8'hEC, 8'hF5, 8'hF8, 8'hFF};
  logic [7:0] msk [4] = '{8'hEF, 8'h03, 8'h00, 8'h8F};
  int fb [6] = '{0, 3, 3, 2, 2, 5};
  pmsf_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .main_supply_low(msl), .dc_input_sense(dcs), .switched_supply_delta(ev[0]),
    .switched_supply_ready(ev[1]), .battery_threshold(ev[2]), .battery_ready(ev[3]),
    .line_sag(ev[4]), .rtc_1hz(rtc), .gpio_pin1_out(gpo), .calib_freq_out_a(calib),
    .battery_control_out(bctl), .irq_pin1_o(p1o), .irq_pin1_oe(p1oe),
    .irq_pin1_in_en(p1ie), .irq_pin0_enable(p0e), .switched_supply(sws),
    .meter_status_read_clear(rclr), .power_irq_summary_flag(sum));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Flag that event k should raise, plus the summary bit if its enable is set
  function automatic logic [7:0] exp_flag(input int k, input logic [7:0] e);
    int b;
    b = fb[(k + 1) % 6];
    return (8'h01 << b) | (e[b] ? 8'h40 : 8'h00);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cyc(1);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1;
    cyc(1);
    sfr_wr = 0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    sfr_addr = a;
    sfr_rd = 1;
    cyc(1);
    sfr_rd = 0;
    chk(sfr_rdata, exp);
  endtask
  task automatic done(input string s);
    $display("test %0s done", s);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #2;
    sys_rst = 0;
    for (int i = 0; i < 4; i++) rdchk(adr[i], 8'h00);
    wr(8'hA5, 8'h5A);
    rdchk(8'hA5, 8'h00);
    done("reset");
    repeat (6) begin
      for (int i = 0; i < 4; i++) begin
        d = xs() & msk[i];
        wr(adr[i], d);
        rdchk(adr[i], d);
        if (i == 0) chk({7'h0, rclr}, {7'h0, d[6]});
        if (i == 3) chk({6'h0, p1ie, p0e}, {6'h0, &d[3:2], d[0]});
      end
    end
    done("registers");
    // Delta and ready share flag 3, threshold and ready share flag 2
    for (int k = 0; k < 6; k++) begin
      en = xs() & 8'hAF;
      wr(8'hEC, en);
      wr(8'hF8, 8'h00);
      if (k == 5) dcs = 1;
      else ev[k] = 1;
      cyc(6);
      dcs = 0;
      ev = 0;
      d = exp_flag(k, en);
      rdchk(8'hF8, d);
      chk({7'h0, sum}, {7'h0, d[6]});
      wr(8'hF8, 8'hEF);
      rdchk(8'hF8, d);
      wr(8'hF8, 8'h00);
      rdchk(8'hF8, 8'h00);
      chk({7'h0, sum}, 8'h00);
    end
    done("events");
    wr(8'hEC, 8'h02);
    wr(8'hF5, 8'h00);
    wr(8'hF8, 8'h00);
    msl = 1;
    cyc(8);
    chk({7'h0, sws}, 8'h01);
    rdchk(8'hF8, 8'h42);
    wr(8'hF8, 8'h00);
    msl = 0;
    cyc(8);
    chk({7'h0, sws}, 8'h00);
    rdchk(8'hF8, 8'h80);
    // Both codes with the upper bit set must block the move
    for (int p = 2; p < 4; p++) begin
      wr(8'hF5, p[7:0]);
      msl = 1;
      cyc(8);
      chk({7'h0, sws}, 8'h00);
      msl = 0;
    end
    wr(8'hF5, 8'h01);
    msl = 1;
    cyc(8);
    chk({7'h0, sws}, 8'h00);
    dcs = 1;
    cyc(8);
    chk({7'h0, sws}, 8'h01);
    wr(8'hFF, 8'h02);
    cyc(3);
    chk({7'h0, bctl}, 8'h01);
    msl = 0;
    dcs = 0;
    cyc(8);
    done("switchover");
    wr(8'hFF, 8'h80);
    rtc = 1;
    cyc(5);
    chk({7'h0, calib}, 8'h01);
    rtc = 0;
    cyc(5);
    chk({7'h0, calib}, 8'h00);
    wr(8'hFF, 8'h00);
    gpo = 1;
    cyc(5);
    chk({6'h0, p1oe, p1o}, 8'h03);
    wr(8'hFF, 8'h0E);
    cyc(3);
    chk({6'h0, p1ie, p1oe}, 8'h02);
    done("pins");
    end_of_test();
  end
endmodule
bind pmsf_top pmsf_monitor i_mon (.sys_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata, .main_supply_low, .calib_freq_out_a, .battery_control_out,
  .irq_pin1_oe, .irq_pin1_in_en, .irq_pin0_enable, .switched_supply,
  .meter_status_read_clear, .power_irq_summary_flag);
`default_nettype wire
